// *** msp_motor_ctrl.v ***
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "msp_regs.vh"
// Behaviour
// - Edge select falling 0 rising 1, preloaded
// - Hardware demag mask preloaded at commutation
// - Simulated demag mask preloaded at commutation
// - Preloads move at commutation; direct write commutates
// - Current limit: PWM off or outputs reset
// - Over-current shutdown works in three-output voltage mode
// - Sensorless: one select bit per interval, three in all
// - Only first select bit is preloaded
// - Mode 00: top bit is overflow flag
// - Other modes: top bit is speed error flag
// - Mode 00: bit 6 selects hardware zero-cross
// - Speed mode: bit 6 reads encoder direction
// - Simulated zero-cross selects simulated event
// - Auto mode: simulated commutation select
// - Fast sampling: continuous versus end of off
// - Fast sampling forces minimum off time zero
// - Threshold code all ones picks external pin
// - Phase register resets zero, all preloaded
// - Channel bits applied at commutation or direct
// - Input select picks A, B, C or encoder
module msp_motor_ctrl (
   input  wire       clk,             // System clock, 100 MHz
   input  wire       nrst,            // Synchronous reset, active low
   input  wire [3:0] addr,            // Register address
   input  wire [7:0] wdata,           // Write data
   input  wire       wr,              // Write strobe
   input  wire       rd,              // Read strobe
   output reg  [7:0] rdata_ff,        // Read data, cycle after rd
   input  wire       hw_comm_evt,     // Hardware commutation event pulse
   input  wire       sim_comm_evt,    // Simulated commutation event pulse
   input  wire       timer_ovf_evt,   // Commutation timer overflow pulse
   input  wire       tacho_err_evt,   // Speed sensor error pulse
   input  wire       pwm_in,          // PWM waveform from generator
   input  wire       pwm_off_end,     // Pulse at end of PWM off time
   input  wire       sample_tick,     // Sampling clock enable pulse
   input  wire [3:0] min_off_time,    // Programmed minimum off time
   input  wire       position_input_a, // Position pin A, asynchronous
   input  wire       position_input_b, // Position pin B, asynchronous
   input  wire       position_input_c, // Position pin C, asynchronous
   input  wire       comp_out,        // Comparator output, asynchronous
   input  wire       current_limit_active, // Current comparator, async
   output reg  [5:0] phase_outputs_ff, // Bridge channel drives
   output reg  [1:0] comp_sel_ff,     // Comparator input A/B/C select
   output reg        encoder_mode_ff, // A and B routed to encoder
   output reg  [2:0] vref_sel_ff,     // Internal threshold code
   output reg        vref_ext_ff,     // External threshold pin selected
   output reg        zc_event_ff,     // Zero-crossing event pulse
   output reg        demag_event_ff,  // Demagnetisation event pulse
   output reg        comm_event_ff,   // Commutation event pulse
   output reg  [3:0] eff_off_time_ff, // Minimum off time in use
   output reg        irq_ff           // Over-current interrupt, high while the synced limit input is high and the limit enable bit is set
);
   // ---------------------------------------------------------------
   // Step phase states
   // ---------------------------------------------------------------
   localparam ST_C_D = 2'b00;         // Commutation to demag
   localparam ST_D_Z = 2'b01;         // Demag to zero-cross
   localparam ST_Z_C = 2'b10;         // Zero-cross to commutation

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg  [7:0] spc_pre_ff;             // Step PWM control, written copy
   reg  [7:0] spc_act_ff;             // Active copy of preload bits
   reg  [6:0] esc_ff;                 // Event sampling control bits 6:0
   reg        flag_ff;                // Overflow / speed error flag
   reg  [7:0] pho_pre_ff;             // Phase state, written copy
   reg  [7:0] pho_act_ff;             // Phase state, active copy
   reg  [8:0] mode_ff;                // Loose mode control bits
   reg  [1:0] step_ff;                // Step interval state
   reg        dir_ff;                 // Encoder direction
   reg        a_d_ff;                 // Delayed synced A
   reg        b_d_ff;                 // Delayed synced B
   reg        cmp_d_ff;               // Delayed synced comparator
   reg        dac_wr_ff;              // Direct access write commutation
   reg  [1:0] nxt_step;               // Next step state
   reg        nxt_flag;               // Next flag value
   reg        pwm_low;                // PWM on low channels now
   reg  [5:0] drive;                  // Channel drive pattern
   wire [4:0] sync_q;                 // Synchronised pin levels
   wire       in_a, in_b, in_c, cmp_s, current_limitation_enable_s;
   wire       comm_evt;               // Commutation event this cycle
   wire       zc_det;                 // Detected zero-crossing edge
   wire       zc_evt;                 // Zero-cross event
   wire       dm_evt;                 // Demag event
   wire       zc_sample;              // Zero-cross sampling strobe
   wire       oc_shut;                // Over-current output reset
   wire       sensor_on  = mode_ff[`MSP_MC_SR];
   wire       dac_on     = mode_ff[`MSP_MC_DAC];
   wire [1:0] tes        = mode_ff[`MSP_MC_TES_LO+1:`MSP_MC_TES_LO];
   wire       speed_mode = (tes != 2'b00);
   wire       wr_spc     = wr && (addr == `MSP_ADDR_STEP_PWM);
   wire       wr_esc     = wr && (addr == `MSP_ADDR_EVENT_SAMPLE);
   wire       wr_pho     = wr && (addr == `MSP_ADDR_PHASE_STATE);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   msp_sync #(.W(5)) u_sync (
      .clk     (clk),
      .nrst    (nrst),
      .din     ({current_limit_active, comp_out, position_input_c,
                 position_input_b, position_input_a}),
      .dout_ff (sync_q)
   );
   assign in_a   = sync_q[0];
   assign in_b   = sync_q[1];
   assign in_c   = sync_q[2];
   assign cmp_s  = sync_q[3];
   assign current_limitation_enable_s = sync_q[4];

   // ---------------------------------------------------------------
   // Event sources
   // ---------------------------------------------------------------
   // Auto mode picks simulated or hardware commutation; switched
   // mode accepts either source
   assign comm_evt = dac_wr_ff ||
      (mode_ff[`MSP_MC_SWA] ? (esc_ff[`MSP_ESC_SIM_COMM] ? sim_comm_evt
                                                         : hw_comm_evt)
                            : (hw_comm_evt | sim_comm_evt));
   // Fast mode samples every sampling tick, normal mode at end of off
   assign zc_sample = esc_ff[`MSP_ESC_FAST] ? sample_tick : pwm_off_end;
   // Edge polarity comes from the active copy only
   assign zc_det = zc_sample && (spc_act_ff[`MSP_SPC_ZC_EDGE] ?
                                 (cmp_s && !cmp_d_ff) : (!cmp_s && cmp_d_ff));
   // Simulated zero-cross replaces detection; hardware select gates it in mode 00
   assign zc_evt = esc_ff[`MSP_ESC_SIM_ZC] ? sample_tick :
                   (zc_det && (speed_mode || esc_ff[`MSP_ESC_DIR_HZ]));
   // Demag by comparator level (hardware) or sample tick (simulated)
   assign dm_evt = (spc_act_ff[`MSP_SPC_HW_DEMAG] && zc_sample && cmp_s) ||
                   (spc_act_ff[`MSP_SPC_SIM_DEMAG] && sample_tick);
   // Voltage mode only; works with three-output config too
   assign oc_shut = mode_ff[`MSP_MC_CURRENT_LIMITATION_ENABLE] && current_limitation_enable_s &&
                    spc_pre_ff[`MSP_SPC_OCV] && !mode_ff[`MSP_MC_VOC];

   // ---------------------------------------------------------------
   // Step interval sequencing
   // ---------------------------------------------------------------
   // Sensor mode skips the demag interval entirely
   always @* begin
      nxt_step = step_ff;
      case (step_ff)
         ST_C_D: begin
            if (sensor_on) begin
               if (zc_evt) nxt_step = ST_Z_C;
            end else if (dm_evt) begin
               nxt_step = ST_D_Z;
            end
         end
         ST_D_Z: begin
            if (zc_evt) nxt_step = ST_Z_C;
         end
         ST_Z_C: nxt_step = step_ff;
         default: nxt_step = ST_C_D;
      endcase
      if (comm_evt) nxt_step = ST_C_D;
   end

   // ---------------------------------------------------------------
   // PWM channel side and drive pattern
   // ---------------------------------------------------------------
   // Middle bit and second interval are live writes, not preloaded
   always @* begin
      if (dac_on) begin
         pwm_low = spc_pre_ff[`MSP_SPC_SEL_LAST];
      end else begin
         case (step_ff)
            ST_C_D:  pwm_low = spc_act_ff[`MSP_SPC_SEL_FIRST];
            ST_D_Z:  pwm_low = spc_pre_ff[`MSP_SPC_SEL_MID];
            ST_Z_C:  pwm_low = spc_pre_ff[`MSP_SPC_SEL_LAST];
            default: pwm_low = 1'b0;
         endcase
      end
      // Even channels are high side, odd are low side
      drive = pho_act_ff[5:0] & (pwm_low ? {3{pwm_in, 1'b1}}
                                         : {3{1'b1, pwm_in}});
      // Current loop effect: limit switches PWM off without reset;
      // only the steady side of the pair stays on
      if (current_limitation_enable_s && !oc_shut)
         drive = pho_act_ff[5:0] & (pwm_low ? 6'h15 : 6'h2A);
   end

   // ---------------------------------------------------------------
   // Flag: overflow in mode 00, speed error otherwise
   // ---------------------------------------------------------------
   // Hardware set wins over a software clear in the same cycle
   always @* begin
      nxt_flag = flag_ff;
      if (wr_esc && !wdata[`MSP_ESC_FLAG])
         nxt_flag = 1'b0;
      if (speed_mode ? tacho_err_evt : timer_ovf_evt)
         nxt_flag = 1'b1;
   end

   // ---------------------------------------------------------------
   // Register writes and preload transfer
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         spc_pre_ff <= `MSP_RST_BYTE;
         spc_act_ff <= `MSP_RST_BYTE;
         esc_ff     <= 7'h00;
         flag_ff    <= 1'b0;
         pho_pre_ff <= `MSP_RST_BYTE;
         pho_act_ff <= `MSP_RST_BYTE;
         mode_ff    <= `MSP_RST_MODE;
         step_ff    <= ST_C_D;
         dac_wr_ff  <= 1'b0;
      end else begin
         flag_ff   <= nxt_flag;
         step_ff   <= nxt_step;
         dac_wr_ff <= wr_pho && dac_on;
         if (wr_spc)
            spc_pre_ff <= {1'b0, wdata[6:0]};
         if (wr_esc) begin
            esc_ff[5:0] <= wdata[5:0];
            if (!speed_mode)
               esc_ff[`MSP_ESC_DIR_HZ] <= wdata[`MSP_ESC_DIR_HZ];
         end
         if (wr && addr == `MSP_ADDR_MODE_CTRL)
            mode_ff <= {wdata[7:0] == 8'hFF ? 1'b1 : 1'b0, wdata};
         if (wr && addr == `MSP_ADDR_STATUS)
            mode_ff[8] <= wdata[0];
         if (wr_pho)
            pho_pre_ff <= wdata;
         // Direct access loads channel bits straight through
         if (wr_pho && dac_on)
            pho_act_ff <= wdata;
         else if (comm_evt)
            pho_act_ff <= pho_pre_ff;
         if (comm_evt)
            spc_act_ff <= spc_pre_ff;
         // Over-current in voltage mode drops the master enable
         if (oc_shut)
            mode_ff[`MSP_MC_MOE] <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Encoder direction from quadrature phase
   // ---------------------------------------------------------------
   // On an A edge, B differing from the new A level means A leads
   always @(posedge clk) begin
      if (!nrst) begin
         a_d_ff   <= 1'b0;
         b_d_ff   <= 1'b0;
         cmp_d_ff <= 1'b0;
         dir_ff   <= 1'b0;
      end else begin
         a_d_ff   <= in_a;
         b_d_ff   <= in_b;
         cmp_d_ff <= cmp_s;
         if (in_a != a_d_ff)
            dir_ff <= (in_a != in_b);
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         phase_outputs_ff <= 6'h00;
         comp_sel_ff      <= 2'b00;
         encoder_mode_ff  <= 1'b0;
         vref_sel_ff      <= 3'h0;
         vref_ext_ff      <= 1'b0;
         zc_event_ff      <= 1'b0;
         demag_event_ff   <= 1'b0;
         comm_event_ff    <= 1'b0;
         eff_off_time_ff  <= 4'h0;
         irq_ff           <= 1'b0;
         rdata_ff         <= 8'h00;
      end else begin
         // Master enable low holds the bridge in its reset state
         phase_outputs_ff <= (mode_ff[`MSP_MC_MOE] && !oc_shut) ? drive : 6'h00;
         comp_sel_ff      <= pho_act_ff[7:6];
         encoder_mode_ff  <= (pho_act_ff[7:6] == 2'b11);
         vref_sel_ff      <= esc_ff[`MSP_ESC_VR_HI:0];
         vref_ext_ff      <= (esc_ff[`MSP_ESC_VR_HI:0] == `MSP_VR_EXTERNAL);
         zc_event_ff      <= zc_evt;
         demag_event_ff   <= dm_evt;
         comm_event_ff    <= comm_evt;
         eff_off_time_ff  <= esc_ff[`MSP_ESC_FAST] ? 4'h0 : min_off_time;
         irq_ff           <= mode_ff[`MSP_MC_CURRENT_LIMITATION_ENABLE] && current_limitation_enable_s;
         // Read mux; unmapped addresses read zero
         rdata_ff <= 8'h00;
         if (rd) begin
            case (addr)
               `MSP_ADDR_STEP_PWM:     rdata_ff <= spc_pre_ff;
               `MSP_ADDR_EVENT_SAMPLE: rdata_ff <= {flag_ff,
                  speed_mode ? dir_ff : esc_ff[`MSP_ESC_DIR_HZ],
                  esc_ff[5:0]};
               `MSP_ADDR_PHASE_STATE:  rdata_ff <= pho_pre_ff;
               `MSP_ADDR_MODE_CTRL:    rdata_ff <= mode_ff[7:0];
               `MSP_ADDR_STATUS:       rdata_ff <= {3'h0, in_c, in_b, in_a,
                                                    step_ff};
               default:                rdata_ff <= 8'h00;
            endcase
         end
      end
   end
endmodule

// *** msp_regs.vh ***
`ifndef MSP_REGS_VH
`define MSP_REGS_VH
// ---------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ---------------------------------------------------------------
`define MSP_ADDR_STEP_PWM      4'h0
`define MSP_ADDR_EVENT_SAMPLE  4'h1
`define MSP_ADDR_PHASE_STATE   4'h2
`define MSP_ADDR_MODE_CTRL     4'h3
`define MSP_ADDR_STATUS        4'h4
// ---------------------------------------------------------------
// Step PWM control field positions
// ---------------------------------------------------------------
`define MSP_SPC_RSVD      7
`define MSP_SPC_ZC_EDGE   6
`define MSP_SPC_HW_DEMAG  5
`define MSP_SPC_SIM_DEMAG 4
`define MSP_SPC_OCV       3
`define MSP_SPC_SEL_FIRST 2
`define MSP_SPC_SEL_MID   1
`define MSP_SPC_SEL_LAST  0
// ---------------------------------------------------------------
// Event sampling control field positions
// ---------------------------------------------------------------
`define MSP_ESC_FLAG      7
`define MSP_ESC_DIR_HZ    6
`define MSP_ESC_SIM_ZC    5
`define MSP_ESC_SIM_COMM  4
`define MSP_ESC_FAST      3
`define MSP_ESC_VR_HI     2
`define MSP_VR_EXTERNAL   3'h7
// ---------------------------------------------------------------
// Mode control field positions (loose control bits)
// ---------------------------------------------------------------
`define MSP_MC_MOE        0
`define MSP_MC_SR         1
`define MSP_MC_DAC        2
`define MSP_MC_VOC        3
`define MSP_MC_SWA        4
`define MSP_MC_CURRENT_LIMITATION_ENABLE       5
`define MSP_MC_PCN        6
`define MSP_MC_TES_LO     7
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MSP_RST_BYTE      8'h00
`define MSP_RST_MODE      9'h000
`endif

// *** msp_sync.v ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two flip-flop synchroniser for a bus of asynchronous levels
// ---------------------------------------------------------------
module msp_sync #(
   parameter W = 1                // Width of the bus
) (
   input  wire         clk,       // System clock
   input  wire         nrst,      // Synchronous reset, active low
   input  wire [W-1:0] din,       // Asynchronous levels
   output reg  [W-1:0] dout_ff    // Synchronised levels
);
   reg [W-1:0] meta_ff;           // First stage, read only by second stage

   // Both stages clear on reset
   always @(posedge clk) begin
      if (!nrst) begin
         meta_ff <= {W{1'b0}};
         dout_ff <= {W{1'b0}};
      end else begin
         meta_ff <= din;
         dout_ff <= meta_ff;
      end
   end
endmodule

// *** msp_bridge_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------
// Bridge and rotor sensor model
// ---------------------------------------------
module msp_bridge_model (
   input  logic       clk,                  // System clock
   input  logic [5:0] phase_outputs_ff,     // Bridge drives from the block
   input  logic       over_cur,             // Bench asks for an over-current
   input  logic       spin,                 // Rotor turns when high
   input  logic       a_leads,              // Turning sense of the rotor
   output logic       position_input_a,     // Encoder track A
   output logic       position_input_b,     // Encoder track B
   output logic       position_input_c,     // Third sensor line
   output logic       comp_out,             // Back-EMF comparator
   output logic       current_limit_active  // Current comparator
);
   logic [3:0] ph_ff = 4'h0;                // Rotor angle, top bits give the track state
   // Angle advances one way or the other only while spinning
   always @(posedge clk) begin
      if (spin) begin
         ph_ff <= a_leads ? ph_ff + 4'h1 : ph_ff - 4'h1;
      end
   end
   // Gray tracks: counting up makes A rise before B
   assign position_input_a = ph_ff[3] ^ ph_ff[2];
   assign position_input_b = ph_ff[3];
   assign position_input_c = ~position_input_a;
   // Comparator follows drive parity and rotor angle bit 2, so it moves only when they do
   assign comp_out = ^phase_outputs_ff ^ ph_ff[2];
   assign current_limit_active = over_cur;
endmodule

// *** msp_chk.sv ***
`timescale 1ns/1ps
module msp_chk (
   input logic       clk,                  // System clock
   input logic       nrst,                 // Synchronous reset, active low
   input logic [3:0] addr,                 // Register address
   input logic [7:0] wdata,                // Write data
   input logic       wr,                   // Write strobe
   input logic       rd,                   // Read strobe
   input logic [7:0] rdata_ff,             // Read data
   input logic       current_limit_active, // Current comparator
   input logic [5:0] phase_outputs_ff,     // Bridge drives
   input logic [2:0] vref_sel_ff,          // Internal threshold code
   input logic       vref_ext_ff,          // External threshold chosen
   input logic       comm_event_ff,        // Commutation pulse
   input logic [3:0] eff_off_time_ff,      // Off time in use
   input logic       irq_ff                // Over-current interrupt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic       dac_ff;                      // Shadow of the direct access bit
   logic [7:0] wd_ff;                       // Last byte written, any address
   // Helper shadows, kept from the bus alone
   always @(posedge clk) begin
      if (!nrst) begin
         dac_ff <= 1'b0;
         wd_ff <= 8'h00;
      end else if (wr) begin
         wd_ff <= wdata;
         if (addr == 4'h3) begin
            dac_ff <= wdata[2];
         end
      end
   end
   sequence s_step_wr;
      wr && addr == 4'h0;
   endsequence
   sequence s_step_rd;
      rd && !wr && addr == 4'h0;
   endsequence
   reset_clear_a: assert property (nrst && !$past(nrst) |-> phase_outputs_ff == 6'h00 && irq_ff == 1'b0 && rdata_ff == 8'h00)
      else $error("outputs not clear after reset");
   read_window_a: assert property (rdata_ff != 8'h00 |-> $past(rd))
      else $error("read data outside its cycle");
   step_readback_a: assert property (s_step_wr ##1 s_step_rd |=> rdata_ff == {1'b0, wd_ff[6:0]})
      else $error("step control readback wrong");
   ext_ref_a: assert property (wr && addr == 4'h1 && wdata[2:0] == 3'h7 |-> ##[1:2] vref_ext_ff)
      else $error("external threshold not chosen");
   int_ref_a: assert property (wr && addr == 4'h1 && wdata[2:0] != 3'h7 |-> ##[1:2] !vref_ext_ff && vref_sel_ff == wd_ff[2:0])
      else $error("internal threshold code wrong");
   fast_off_a: assert property (wr && addr == 4'h1 && wdata[3] |-> ##[1:2] eff_off_time_ff == 4'h0)
      else $error("off time not forced to zero");
   direct_comm_a: assert property (wr && addr == 4'h2 && dac_ff |-> ##[1:3] comm_event_ff)
      else $error("direct write gave no commutation");
   irq_cause_a: assert property (irq_ff |-> $past(current_limit_active, 2) || $past(current_limit_active, 3) || $past(current_limit_active, 4) || $past(current_limit_active, 5))
      else $error("interrupt without current limit");
endmodule
bind msp_motor_ctrl msp_chk i_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .current_limit_active(current_limit_active), .phase_outputs_ff(phase_outputs_ff), .vref_sel_ff(vref_sel_ff), .vref_ext_ff(vref_ext_ff), .comm_event_ff(comm_event_ff), .eff_off_time_ff(eff_off_time_ff), .irq_ff(irq_ff));

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
   logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;     // Clock, reset, strobes
   logic [3:0] addr = 4'h0, min_off_time = 4'h5;                // Address, programmed off time
   logic [7:0] wdata = 8'h00;                                   // Write data
   logic       hw_comm_evt = 1'b0, sim_comm_evt = 1'b0;         // Commutation pulses
   logic       timer_ovf_evt = 1'b0, tacho_err_evt = 1'b0;      // Timer and speed pulses
   logic       pwm_in = 1'b1, pwm_off_end = 1'b0, sample_tick = 1'b0; // PWM timing
   logic       over_cur = 1'b0, spin = 1'b0, a_leads = 1'b1;    // Model controls
   wire        pa, pb, pc, cmp, cla, enc, zc, dm, comm, vext, irq; // Observed bits
   wire  [7:0] rdata_ff;                                        // Read data
   wire  [5:0] ph;                                              // Bridge drives
   wire  [1:0] csel;                                            // Comparator select
   wire  [2:0] vsel;                                            // Threshold code
   wire  [3:0] eoff;                                            // Off time in use
   int         fails = 0, comparisons = 0;                      // Tallies
   always #5 clk = ~clk;
   // Sampling ticks every other cycle, off-time ends follow them
   always @(posedge clk) begin
      sample_tick <= ~sample_tick;
      pwm_off_end <= sample_tick;
   end
   msp_bridge_model i_bridge (.clk(clk), .phase_outputs_ff(ph), .over_cur(over_cur),
      .spin(spin), .a_leads(a_leads), .position_input_a(pa), .position_input_b(pb),
      .position_input_c(pc), .comp_out(cmp), .current_limit_active(cla));
   msp_motor_ctrl i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_ff(rdata_ff), .hw_comm_evt(hw_comm_evt), .sim_comm_evt(sim_comm_evt),
      .timer_ovf_evt(timer_ovf_evt), .tacho_err_evt(tacho_err_evt), .pwm_in(pwm_in),
      .pwm_off_end(pwm_off_end), .sample_tick(sample_tick), .min_off_time(min_off_time),
      .position_input_a(pa), .position_input_b(pb), .position_input_c(pc), .comp_out(cmp),
      .current_limit_active(cla), .phase_outputs_ff(ph), .comp_sel_ff(csel),
      .encoder_mode_ff(enc), .vref_sel_ff(vsel), .vref_ext_ff(vext), .zc_event_ff(zc),
      .demag_event_ff(dm), .comm_event_ff(comm), .eff_off_time_ff(eoff), .irq_ff(irq));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bus tasks start just after an edge; the next task takes over the strobes
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      wr <= 1'b1; rd <= 1'b0; addr <= a; wdata <= d;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      rd <= 1'b1; wr <= 1'b0; addr <= a;
      @(posedge clk);
      #1 check(rdata_ff, e);
   endtask
   task automatic idle(input int n);
      wr <= 1'b0; rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait for a drive pattern; running out ends the run
   task automatic wait_ph(input logic [5:0] e);
      int i;
      for (i = 0; i < 20 && ph !== e; i++) @(posedge clk);
      check({2'h0, ph}, {2'h0, e});
      if (i == 20) give_verdict;
   endtask
   task automatic hw_comm;
      hw_comm_evt <= 1'b1; idle(1); hw_comm_evt <= 1'b0;
   endtask
   task automatic t_reset;
      rd_chk(4'h0, 8'h00);
      rd_chk(4'h1, 8'h00);
      rd_chk(4'h2, 8'h00);
      rd_chk(4'h9, 8'h00);
      wr_reg(4'h0, 8'hFF);
      rd_chk(4'h0, 8'h7F);
      wr_reg(4'h0, 8'h00);
      $display("reset and step done");
   endtask
   // Phase bits wait for the commutation unless direct access is on
   task automatic t_preload;
      wr_reg(4'h3, 8'h01);
      wr_reg(4'h2, 8'h8F);
      idle(4);
      check({2'h0, ph}, 8'h00);
      check({6'h0, csel}, 8'h00);
      hw_comm;
      wait_ph(6'h0F);
      check({6'h0, csel}, 8'h02);
      wr_reg(4'h2, 8'hC0);
      hw_comm;
      wait_ph(6'h00);
      check({7'h0, enc}, 8'h01);
      wr_reg(4'h3, 8'h05);
      wr_reg(4'h2, 8'h3F);
      wait_ph(6'h3F);
      pwm_in <= 1'b0;
      wr_reg(4'h0, 8'h00);
      idle(3);
      check({2'h0, ph}, 8'h2A);
      wr_reg(4'h0, 8'h01);
      idle(3);
      check({2'h0, ph}, 8'h15);
      pwm_in <= 1'b1;
      $display("preload and direct done");
   endtask
   // Over-current in three-output voltage mode drops every drive
   task automatic t_ovc;
      int i;
      wr_reg(4'h0, 8'h08);
      wr_reg(4'h3, 8'h61);
      idle(2);
      over_cur <= 1'b1;
      for (i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
      check({7'h0, irq}, 8'h01);
      wait_ph(6'h00);
      over_cur <= 1'b0;
      rd_chk(4'h3, 8'h60);
      $display("over-current done");
   endtask
   task automatic t_flag;
      logic [3:0] c;
      wr_reg(4'h1, 8'h00);
      timer_ovf_evt <= 1'b1; idle(1); timer_ovf_evt <= 1'b0;
      rd_chk(4'h1, 8'h80);
      wr_reg(4'h1, 8'h80);
      rd_chk(4'h1, 8'h80);
      wr_reg(4'h1, 8'h40);
      rd_chk(4'h1, 8'h40);
      for (c = 4'h0; c < 4'h8; c++) begin
         wr_reg(4'h1, {5'h00, c[2:0]});
         idle(2);
         check({7'h0, vext}, {7'h0, c == 4'h7});
      end
      wr_reg(4'h1, 8'h08);
      idle(2);
      check({4'h0, eoff}, 8'h00);
      wr_reg(4'h1, 8'h00);
      idle(2);
      check({4'h0, eoff}, 8'h05);
      wr_reg(4'h1, 8'h20);
      idle(2);
      c = 4'h0;
      repeat (4) begin
         @(posedge clk);
         #1 c = c + {3'h0, zc};
      end
      check({4'h0, c}, 8'h02);
      wr_reg(4'h1, 8'h00);
      idle(2);
      $display("flags and sampling done");
   endtask
   // Speed mode: bit 6 follows the track order, bit 7 the speed error
   task automatic t_enc;
      wr_reg(4'h3, 8'h05);
      wr_reg(4'h2, 8'hC0);
      wr_reg(4'h4, 8'h01);
      spin <= 1'b1;
      idle(40);
      tacho_err_evt <= 1'b1; idle(1); tacho_err_evt <= 1'b0;
      rd_chk(4'h1, 8'hC0);
      a_leads <= 1'b0;
      idle(40);
      rd_chk(4'h1, 8'h80);
      spin <= 1'b0;
      $display("encoder done");
   endtask
   initial begin
      #500000 fails++;
      give_verdict;
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_preload;
      t_ovc;
      t_flag;
      t_enc;
      idle(2);
      give_verdict;
   end
endmodule
